// >>> design/wdu_top.sv
// Watchdog timer unit top with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wdu_top import wdu_pkg::*; #(
	parameter int unsigned BASE = BASE_TICKS,
	parameter int unsigned DIV = WDOSC_DIV
) (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	// Safety level fuse, high when programmed
	input wire logic WD_SAFETY_FUSE_IN,
	// AXI4-Lite write address
	input wire logic [7:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	// AXI4-Lite write data
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	// AXI4-Lite write response
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	// AXI4-Lite read
	input wire logic [7:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	// Chip reset request and interrupt
	output logic WD_RESET_OUT,
	output logic IRQ_OUT
);
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		is_reg = a == off;
	endfunction
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = is_reg(a, OFF_CTRL) || is_reg(a, OFF_FLAG) || is_reg(a, OFF_RESTART)
			|| is_reg(a, OFF_IRQ_STS) || is_reg(a, OFF_IRQ_CLR) || is_reg(a, OFF_IRQ_EN)
			|| is_reg(a, OFF_COUNT);
	endfunction

	// Held write channels
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// Control state
	logic fuse;
	logic enable_bit;
	logic [2:0] sel;
	logic [2:0] unlock_cnt;
	logic wd_reset_flag;
	logic [IRQ_W-1:0] irq_sts;
	logic [IRQ_W-1:0] irq_en;
	logic [$clog2(DIV)-1:0] div_cnt;
	logic tick;
	logic [CNT_W-1:0] wd_count;
	logic expire;

	wire wr_fire = aw_held && w_held && !BVALID_OUT;
	wire wr_lane0 = wr_fire && w_strb[0];
	wire wr_ctrl = wr_lane0 && is_reg(aw_addr, OFF_CTRL);
	wire wr_flag = wr_lane0 && is_reg(aw_addr, OFF_FLAG);
	wire wr_restart = wr_lane0 && is_reg(aw_addr, OFF_RESTART);
	wire wr_irq_clr = wr_lane0 && is_reg(aw_addr, OFF_IRQ_CLR);
	wire wr_irq_en = wr_lane0 && is_reg(aw_addr, OFF_IRQ_EN);
	wire wr_ok = is_mapped(aw_addr);
	wire rd_fire = ARVALID_IN && ARREADY_OUT;
	wire rd_ok = is_mapped(ARADDR_IN);

	wire change_unlock = unlock_cnt != 3'h0;
	wire eff_enable = enable_bit || fuse; // [RL10]
	wire wd_unlock_w = w_data[BIT_UNLOCK];
	wire wd_enable_w = w_data[BIT_ENABLE];
	wire [2:0] wd_sel_w = w_data[BIT_SEL_HI:0];

	// Enable: a written one always starts; zero stops only while unlocked, never with the fuse
	wire next_enable = !wr_ctrl ? enable_bit :
		wd_enable_w ? 1'b1 : // [RL6] [RL8]
		(change_unlock && !fuse) ? 1'b0 : enable_bit; // [RL6] [RL9] [RL11]
	// Prescaler changes only inside an open window; the enable written then is irrelevant with the fuse programmed
	wire [2:0] next_sel = (wr_ctrl && change_unlock) ? wd_sel_w : sel; // [RL9] [RL11]
	wire [2:0] next_unlock_cnt = (wr_ctrl && wd_unlock_w) ? UNLOCK_LOAD :
		change_unlock ? unlock_cnt - 3'h1 : 3'h0; // [RL5]

	wire wdu_ctrl_t ctrl_view = '{change_unlock: change_unlock, enable: eff_enable, sel: sel};
	wire [31:0] ctrl_word = {24'h00_0000, 3'h0, ctrl_view}; // [RL4]
	wire [31:0] rd_word =
		is_reg(ARADDR_IN, OFF_CTRL) ? ctrl_word :
		is_reg(ARADDR_IN, OFF_FLAG) ? {31'h0000_0000, wd_reset_flag} :
		is_reg(ARADDR_IN, OFF_IRQ_STS) ? {{(32-IRQ_W){1'b0}}, irq_sts} :
		is_reg(ARADDR_IN, OFF_IRQ_EN) ? {{(32-IRQ_W){1'b0}}, irq_en} :
		is_reg(ARADDR_IN, OFF_COUNT) ? {{(32-CNT_W){1'b0}}, wd_count} : ZERO_WORD;

	wire [IRQ_W-1:0] irq_set = {wr_ctrl && wd_unlock_w, WD_RESET_OUT};
	wire [IRQ_W-1:0] irq_clr = wr_irq_clr ? w_data[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] next_irq_sts = (irq_sts & ~irq_clr) | irq_set;
	wire next_irq = |(next_irq_sts & irq_en);

	// Restart on command, on our own chip reset pulse, or while disabled
	wire restart = wr_restart || WD_RESET_OUT; // [RL2]
	wire wdu_ctrl_t cnt_cfg = '{change_unlock: change_unlock, enable: eff_enable, sel: sel};

	// Oscillator-rate enable pulse
	always_ff @(posedge REF_CLK_IN) begin
		if (!NRST_IN) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= div_cnt == $bits(div_cnt)'(DIV - 1); // [RL1]
			div_cnt <= (div_cnt == $bits(div_cnt)'(DIV - 1)) ? '0 : div_cnt + 1'b1;
		end
	end

	// Single clock, so configuration and restart take effect at the next edge [RL14]
	wdu_counter #(
		.BASE(BASE)
	) u_counter (
		.clk_in(REF_CLK_IN),
		.rst_n_in(NRST_IN),
		.tick_in(tick),
		.restart_in(restart),
		.cfg_in(cnt_cfg),
		.count_out(wd_count),
		.expire_out(expire)
	);

	// Write channels
	always_ff @(posedge REF_CLK_IN) begin
		if (!NRST_IN) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= ZERO_WORD;
			w_strb <= 4'h0;
			AWREADY_OUT <= 1'b1;
			WREADY_OUT <= 1'b1;
			BVALID_OUT <= 1'b0;
			BRESP_OUT <= RESP_OKAY;
		end else begin
			if (AWVALID_IN && AWREADY_OUT) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR_IN;
				AWREADY_OUT <= 1'b0;
			end
			if (WVALID_IN && WREADY_OUT) begin
				w_held <= 1'b1;
				w_data <= WDATA_IN;
				w_strb <= WSTRB_IN;
				WREADY_OUT <= 1'b0;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				BVALID_OUT <= 1'b1;
				BRESP_OUT <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (BVALID_OUT && BREADY_IN) begin
				BVALID_OUT <= 1'b0;
				AWREADY_OUT <= 1'b1;
				WREADY_OUT <= 1'b1;
			end
		end
	end

	// Read channel
	always_ff @(posedge REF_CLK_IN) begin
		if (!NRST_IN) begin
			ARREADY_OUT <= 1'b1;
			RVALID_OUT <= 1'b0;
			RDATA_OUT <= ZERO_WORD;
			RRESP_OUT <= RESP_OKAY;
		end else if (rd_fire) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT <= 1'b1;
			RDATA_OUT <= rd_word;
			RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID_OUT && RREADY_IN) begin
			ARREADY_OUT <= 1'b1;
			RVALID_OUT <= 1'b0;
		end
	end

	// Control register and fuse level
	always_ff @(posedge REF_CLK_IN) begin
		if (!NRST_IN) begin
			fuse <= 1'b0;
			enable_bit <= 1'b0; // [RL8]
			sel <= SEL_RESET;
			unlock_cnt <= 3'h0;
		end else begin
			fuse <= WD_SAFETY_FUSE_IN;
			enable_bit <= next_enable;
			sel <= next_sel;
			unlock_cnt <= WD_RESET_OUT ? 3'h0 : next_unlock_cnt;
		end
	end

	// Reset pulse, reset flag and interrupt
	always_ff @(posedge REF_CLK_IN) begin
		if (!NRST_IN) begin
			WD_RESET_OUT <= 1'b0;
			wd_reset_flag <= 1'b0; // [RL13]
			irq_sts <= '0;
			irq_en <= '0;
			IRQ_OUT <= 1'b0;
		end else begin
			WD_RESET_OUT <= expire && !WD_RESET_OUT; // [RL3] [RL12]
			if (WD_RESET_OUT) begin
				wd_reset_flag <= 1'b1; // [RL13]
			end else if (wr_flag && !w_data[BIT_FLAG]) begin
				wd_reset_flag <= 1'b0; // [RL13]
			end
			irq_sts <= next_irq_sts;
			if (wr_irq_en) begin
				irq_en <= w_data[IRQ_W-1:0];
			end
			IRQ_OUT <= next_irq;
		end
	end

	// Checks
	sequence s_open;
		wr_ctrl && wd_unlock_w;
	endsequence
	sequence s_quiet4;
		(!wr_ctrl)[*4];
	endsequence

	a_unlock_holds: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL5]
		s_open |=> change_unlock[*4])
		else $error("unlock bit dropped early");
	a_unlock_closes: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL5]
		s_open ##1 s_quiet4 |=> !change_unlock)
		else $error("unlock bit not cleared after four cycles");
	a_enable_start: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL6]
		wr_ctrl && wd_enable_w |=> eff_enable)
		else $error("enable write did not start watchdog");
	a_locked_enable: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL6]
		wr_ctrl && !change_unlock && eff_enable |=> eff_enable)
		else $error("watchdog stopped without unlock");
	a_unlocked_stop: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL9]
		wr_ctrl && change_unlock && !wd_enable_w && !fuse |=> !eff_enable)
		else $error("unlocked disable ignored");
	a_fuse_enable: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL10]
		rd_fire && is_reg(ARADDR_IN, OFF_CTRL) && fuse |=> RDATA_OUT[BIT_ENABLE])
		else $error("enable reads zero with fuse programmed");
	a_sel_locked: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL11]
		wr_ctrl && !change_unlock |=> sel == $past(sel))
		else $error("prescaler changed without unlock");
	a_reserved_zero: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL4]
		rd_fire && is_reg(ARADDR_IN, OFF_CTRL) |=> RDATA_OUT[31:5] == 27'h000_0000)
		else $error("reserved control bits read nonzero");
	a_pulse_single: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL12]
		$rose(WD_RESET_OUT) |=> !WD_RESET_OUT ##1 wd_count == '0)
		else $error("reset pulse longer than one cycle");
	a_timeout_reset: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL3]
		expire |=> WD_RESET_OUT && wd_reset_flag == $past(wd_reset_flag))
		else $error("time-out did not reset chip");
	a_flag_set: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL13]
		WD_RESET_OUT |=> wd_reset_flag)
		else $error("reset flag not set");
	a_restart_zero: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL2]
		wr_restart || !eff_enable |=> wd_count == '0)
		else $error("count not restarted");
	a_idle_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) // [RL3]
		!eff_enable |=> !WD_RESET_OUT)
		else $error("reset while disabled");
endmodule

// >>> design/wdu_pkg.sv
// Package with register map, field layout and timing constants of the watchdog timer unit
// Behaviour
// RL1: The watchdog counter advances on its own 1 MHz oscillator rate, independent of bus traffic.
// RL2: The count restarts from zero on a restart command, while disabled, and on any chip reset.
// RL3: When the selected period elapses while enabled and unrestarted, the chip is reset.
// RL4: Control register bits 7 to 5 always read zero and ignore writes.
// RL5: The change-unlock bit, once written to one, clears itself four clock cycles later.
// RL6: Writing enable one starts the watchdog; writing zero stops it only while unlock reads one.
// RL7: The three prescaler bits select 16,384 doubling up to 2,097,152 oscillator cycles.
// RL8: With the safety fuse unprogrammed the watchdog starts disabled and may be enabled freely.
// RL9: At the lower level software opens the window with unlock and enable, then commits within four cycles.
// RL10: With the safety fuse programmed the watchdog is always enabled and enable reads one.
// RL11: At the higher level a prescaler change needs the window, and the enable value written is ignored.
// RL12: A time-out drives a chip reset pulse of exactly one system clock cycle.
// RL13: A watchdog reset sets the reset flag, cleared only by power-on reset or a written zero.
// RL14: Restart, enable and prescaler changes reach the oscillator-rate logic without losing events.
package wdu_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned WDOSC_PERIOD_NS = 1000;
	localparam int unsigned WDOSC_DIV = WDOSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned BASE_TICKS = 16384;
	localparam int unsigned UNLOCK_CYCLES = 4;
	localparam int unsigned CNT_W = 21;
	localparam int unsigned IRQ_W = 2;
	localparam logic [2:0] UNLOCK_LOAD = 3'h4;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAG = 8'h04;
	localparam logic [7:0] OFF_RESTART = 8'h08;
	localparam logic [7:0] OFF_IRQ_STS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFF_IRQ_EN = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	// Control field positions
	localparam int unsigned BIT_UNLOCK = 4;
	localparam int unsigned BIT_ENABLE = 3;
	localparam int unsigned BIT_SEL_HI = 2;
	localparam int unsigned BIT_FLAG = 0;
	localparam int unsigned IRQ_TIMEOUT = 0;
	localparam int unsigned IRQ_UNLOCK = 1;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	typedef struct packed {
		logic change_unlock;
		logic enable;
		logic [2:0] sel;
	} wdu_ctrl_t;
endpackage

// >>> design/wdu_counter.sv
// Oscillator-rate watchdog counter with prescaled time-out detection
`timescale 1ns/1ps
module wdu_counter import wdu_pkg::*; #(
	parameter int unsigned BASE = BASE_TICKS
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic restart_in,
	input wire wdu_ctrl_t cfg_in,
	output logic [CNT_W-1:0] count_out,
	output logic expire_out
);
	logic [CNT_W-1:0] count;
	wire [CNT_W-1:0] limit = CNT_W'(BASE) << cfg_in.sel; // [RL7]
	wire at_end = count == (limit - CNT_W'(1));
	assign expire_out = tick_in && at_end && cfg_in.enable; // [RL3]
	assign count_out = count;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || restart_in || !cfg_in.enable || expire_out) begin
			count <= '0; // [RL2]
		end else if (tick_in) begin
			count <= count + CNT_W'(1); // [RL1]
		end
	end
endmodule

// >>> bench/wdu_testbench.sv
// Self-checking testbench for the watchdog timer unit
`timescale 1ns/1ps
module testbench import wdu_pkg::*;;
	localparam int unsigned TB_BASE = 16;
	localparam int unsigned TB_DIV = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic fuse = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = ZERO_WORD;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wd_reset, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	int fail_count = 0;
	int n_tests = 0;
	int hi_cyc = 0;
	int n, h0;
	always #5 clk = ~clk;
	always @(posedge clk) if (wd_reset === 1'b1) hi_cyc <= hi_cyc + 1;
	wdu_top #(.BASE(TB_BASE), .DIV(TB_DIV)) wdu_top_inst (.REF_CLK_IN(clk), .NRST_IN(nrst),
		.WD_SAFETY_FUSE_IN(fuse), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
		.AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
		.RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .WD_RESET_OUT(wd_reset),
		.IRQ_OUT(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write with optional back-to-back start and held bready
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit keep, input bit now);
		if (!now) @(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		if (!keep) bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// Open the change window, then commit at once
	task automatic unlock(input logic [7:0] v);
		wr(OFF_CTRL, 32'h0000_0018, 1'b1, 1'b0);
		wr(OFF_CTRL, {24'h00_0000, v}, 1'b0, 1'b1);
	endtask
	task automatic wait_pulse();
		n = 0;
		while (wd_reset !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(OFF_CTRL);
		chk(rd, ZERO_WORD);
		chk(32'(resp), 32'(RESP_OKAY));
		rd_reg(OFF_FLAG);
		chk(rd, ZERO_WORD);
		wr(OFF_CTRL, 32'h0000_00E8, 1'b0, 1'b0);
		chk(32'(resp), 32'(RESP_OKAY));
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0008);
		$display("test reset and enable done");
		for (int i = 0; i < 6; i++) begin
			wr(OFF_RESTART, 32'h0000_0001, 1'b0, 1'b0);
			repeat (20) @(posedge clk);
		end
		chk(32'(hi_cyc), 32'h0000_0000);
		wr(OFF_CTRL, ZERO_WORD, 1'b0, 1'b0);
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0008);
		wr(OFF_CTRL, 32'h0000_0018, 1'b0, 1'b0);
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0018);
		repeat (6) @(posedge clk);
		wr(OFF_CTRL, ZERO_WORD, 1'b0, 1'b0);
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0008);
		$display("test restart and window done");
		for (int s = 0; s < 8; s++) begin
			wr(OFF_RESTART, 32'h0000_0001, 1'b0, 1'b0);
			unlock(8'h08 | 8'(s));
			rd_reg(OFF_CTRL);
			chk(rd, 32'h0000_0008 | 32'(s));
			wr(OFF_RESTART, 32'h0000_0001, 1'b0, 1'b0);
			h0 = hi_cyc;
			wait_pulse();
			chk(32'(n + 8 >= (TB_BASE << s) * TB_DIV && n <= (TB_BASE << s) * TB_DIV + 8), 1);
			repeat (3) @(posedge clk);
			chk(32'(hi_cyc - h0), 32'h0000_0001);
		end
		rd_reg(OFF_FLAG);
		chk(rd, 32'h0000_0001);
		wr(OFF_FLAG, ZERO_WORD, 1'b0, 1'b0);
		rd_reg(OFF_FLAG);
		chk(rd, ZERO_WORD);
		$display("test prescaler and time-out done");
		unlock(8'h00);
		rd_reg(OFF_CTRL);
		chk(rd, ZERO_WORD);
		h0 = hi_cyc;
		repeat (300) @(posedge clk);
		rd_reg(OFF_COUNT);
		chk(rd, ZERO_WORD);
		chk(32'(hi_cyc - h0), ZERO_WORD);
		$display("test disable done");
		chk(32'(irq), ZERO_WORD);
		wr(OFF_IRQ_EN, 32'h0000_0003, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0001);
		wr(OFF_IRQ_CLR, 32'h0000_0003, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		chk(32'(irq), ZERO_WORD);
		rd_reg(OFF_IRQ_STS);
		chk(rd, ZERO_WORD);
		wr(8'h1C, 32'h0000_00FF, 1'b0, 1'b0);
		chk(32'(resp), 32'(RESP_SLVERR));
		rd_reg(8'h1C);
		chk(rd, ZERO_WORD);
		chk(32'(resp), 32'(RESP_SLVERR));
		$display("test interrupt and unmapped done");
		fuse <= 1'b1;
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0008);
		unlock(8'h02);
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_000A);
		wr(OFF_RESTART, 32'h0000_0001, 1'b0, 1'b0);
		wait_pulse();
		chk(32'(n + 8 >= (TB_BASE << 2) * TB_DIV && n <= (TB_BASE << 2) * TB_DIV + 8), 1);
		$display("test safety fuse done");
		rd_reg(OFF_FLAG);
		chk(rd, 32'h0000_0001);
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(OFF_FLAG);
		chk(rd, ZERO_WORD);
		rd_reg(OFF_CTRL);
		chk(rd, 32'h0000_0008);
		$display("test power-on reset done");
		tally_and_finish();
	end
endmodule
